// file: hw/rca_pkg.sv
package rca_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned PC_W = 13;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned QUARTERS = 4;

  typedef enum logic [3:0] {
    QUARTER_PHASE_ONE = 4'h1,
    QUARTER_PHASE_TWO = 4'h2,
    QUARTER_PHASE_THREE = 4'h4,
    QUARTER_PHASE_FOUR = 4'h8
  } rca_phase_t;

  // the op field of file and literal instructions is this code as is
  typedef enum logic [3:0] {
    ALU_PASS_A = 4'h0,
    ALU_ZERO = 4'h1,
    ALU_SUB = 4'h2,
    ALU_DEC = 4'h3,
    ALU_OR = 4'h4,
    ALU_AND = 4'h5,
    ALU_XOR = 4'h6,
    ALU_ADD = 4'h7,
    ALU_PASS_B = 4'h8,
    ALU_COM = 4'h9,
    ALU_INC = 4'ha,
    ALU_RR = 4'hb,
    ALU_RL = 4'hc,
    ALU_SWAP = 4'hd
  } rca_alu_op_t;
  localparam logic [3:0] OP_LAST = 4'hd;

  // instruction fields
  localparam logic [1:0] CLS_FILE = 2'h0;
  localparam logic [1:0] CLS_RSVD = 2'h1;
  localparam logic [1:0] CLS_GOTO = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam int unsigned CLS_HI = 13;
  localparam int unsigned CLS_LO = 12;
  localparam int unsigned OP_HI = 11;
  localparam int unsigned OP_LO = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned GOTO_W = 12;

  // special function registers, decoded in every bank
  localparam logic [6:0] INDF_ADDR = 7'h00;
  localparam logic [6:0] PCL_ADDR = 7'h02;
  localparam logic [6:0] STATUS_ADDR = 7'h03;
  localparam logic [6:0] FSR_ADDR = 7'h04;

  // status bits
  localparam int unsigned C_BIT = 0;
  localparam int unsigned HC_BIT = 1;
  localparam int unsigned Z_BIT = 2;
  localparam int unsigned RP_BIT = 5;

  localparam logic [12:0] PC_RESET = 13'h1fff;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [7:0] FSR_RESET = 8'h00;
  localparam logic [13:0] NOP_INSTR = 14'h1000;
endpackage

// file: hw/rca_alu_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rca_alu_if import rca_pkg::*; ();
  logic [7:0] a;
  logic [7:0] b;
  rca_alu_op_t op;
  logic cin;
  logic [7:0] result;
  logic cout;
  logic dcout;
  logic zout;
  modport core (output a, b, op, cin, input result, cout, dcout, zout);
  modport unit (input a, b, op, cin, output result, cout, dcout, zout);
endinterface
`default_nettype wire

// file: hw/rca_alu.sv
`timescale 1ns/10ps
`default_nettype none
module rca_alu import rca_pkg::*; (
  rca_alu_if.unit alu // operands in, result and flags out
);
  logic [8:0] wide;
  logic [4:0] nib;

  always_comb begin
    wide = 9'h000;
    nib = 5'h00;
    alu.result = alu.b;
    alu.cout = alu.cin;
    alu.dcout = 1'b0;
    case (alu.op)
      ALU_PASS_A: alu.result = alu.a;
      ALU_ZERO: alu.result = 8'h00;
      ALU_SUB: begin
        // b minus w as b plus not w plus one: carry out means no borrow
        wide = {1'b0, alu.b} + {1'b0, ~alu.a} + 9'h001;
        nib = {1'b0, alu.b[3:0]} + {1'b0, ~alu.a[3:0]} + 5'h01;
        alu.result = wide[7:0];
        alu.cout = wide[8];
        alu.dcout = nib[4];
      end
      ALU_DEC: alu.result = alu.b - 8'h01;
      ALU_OR: alu.result = alu.a | alu.b;
      ALU_AND: alu.result = alu.a & alu.b;
      ALU_XOR: alu.result = alu.a ^ alu.b;
      ALU_ADD: begin
        wide = {1'b0, alu.a} + {1'b0, alu.b};
        nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
        alu.result = wide[7:0];
        alu.cout = wide[8];
        alu.dcout = nib[4];
      end
      ALU_PASS_B: alu.result = alu.b;
      ALU_COM: alu.result = ~alu.b;
      ALU_INC: alu.result = alu.b + 8'h01;
      ALU_RR: begin
        alu.result = {alu.cin, alu.b[7:1]};
        alu.cout = alu.b[0];
      end
      ALU_RL: begin
        alu.result = {alu.b[6:0], alu.cin};
        alu.cout = alu.b[7];
      end
      ALU_SWAP: alu.result = {alu.b[3:0], alu.b[7:4]};
      default: alu.result = alu.b;
    endcase
    alu.zout = (alu.result == 8'h00);
  end
endmodule
`default_nettype wire

// file: hw/rca_core.sv
// Notes on behaviour
// - Each whole 14-bit instruction is read over the program bus in one instruction cycle, apart from the data bus.
// - The next instruction is fetched while the current one executes, so plain instructions take one cycle.
// - The arithmetic unit is 8 bits wide and adds, subtracts, shifts and does bitwise logic.
// - Arithmetic treats operands and results as two's complement.
// - Two-operand work takes one operand from W and the other from a file register or a literal.
// - Single-operand work takes its operand from a file register, from the literal in the literal form, or from W for ALU_PASS_A.
// - W is an 8-bit register for operands and results with no data memory address.
// - Carry, half carry and zero in the status register follow the result as the instruction dictates.
// - In subtraction carry is set when there is no borrow out of the byte and half carry when there is none out of the low nibble.
// - Arithmetic and logic work between W and any file register.
// - Every special register, the low byte of the program counter too, sits in data memory, reachable directly or indirectly.
// - Any operation works on any register through any addressing mode.
// - When selected, the clock pin carries the instruction rate, a quarter of the core clock.
// - The core clock is divided by four into non-overlapping quarter phases forming one instruction cycle.
// - Instructions that change the program counter take two cycles since the prefetched word is dropped.
// - The data operand is read in the second quarter and the destination written in the fourth.
`timescale 1ns/10ps
`default_nettype none
module rca_core import rca_pkg::*; (
  input wire logic sys_clk, // internal core clock
  input wire logic reset, // synchronous, active high
  output logic [12:0] prog_addr, // program memory address
  input wire logic [13:0] prog_data, // instruction word
  output logic [7:0] data_addr, // data memory address
  output logic data_rd_en, // operand read strobe
  input wire logic [7:0] data_rd, // operand read data
  output logic data_wr_en, // destination write strobe
  output logic [7:0] data_wr, // destination write data
  input wire logic clk_out_sel, // clock output function selected
  output logic instr_rate_clock_out // instruction rate clock
);
  rca_alu_if alu ();

  rca_phase_t q_reg, q_next;
  logic [12:0] pc_reg, pc_next;
  logic [13:0] fetch_reg, fetch_next;
  logic [13:0] ir_reg, ir_next;
  logic ir_valid_reg, ir_valid_next;
  logic branch_pend_reg, branch_pend_next;
  logic [12:0] target_reg, target_next;
  logic [7:0] w_reg, w_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] fsr_reg, fsr_next;
  logic [7:0] opnd_reg, opnd_next;
  logic [7:0] res_reg, res_next;
  logic rc_reg, rc_next;
  logic rdc_reg, rdc_next;
  logic rz_reg, rz_next;
  logic [7:0] data_addr_reg, data_addr_next;
  logic clk_out_reg, clk_out_next;

  // decode of the executing instruction
  logic [1:0] cls;
  logic is_lit;
  logic is_goto;
  logic op_ok;
  rca_alu_op_t alu_op;
  logic reads_file;
  logic dest_w;
  logic dest_f;
  logic upd_c;
  logic upd_hc;
  logic upd_z;
  logic int_hit;
  logic [7:0] int_rd;
  logic branch_now;

  rca_alu u_alu (
    .alu(alu.unit)
  );

  assign cls = ir_reg[CLS_HI:CLS_LO];
  assign is_lit = (cls == CLS_LIT);
  assign is_goto = (cls == CLS_GOTO);
  assign op_ok = (ir_reg[OP_HI:OP_LO] <= OP_LAST);
  assign alu_op = rca_alu_op_t'(ir_reg[OP_HI:OP_LO]);

  always_comb begin
    reads_file = 1'b0;
    dest_w = 1'b0;
    dest_f = 1'b0;
    upd_c = 1'b0;
    upd_hc = 1'b0;
    upd_z = 1'b0;
    if ((cls == CLS_FILE || is_lit) && op_ok) begin
      // same op codes for file and literal forms keep the set orthogonal
      dest_w = is_lit || !ir_reg[DEST_BIT];
      dest_f = !is_lit && ir_reg[DEST_BIT];
      reads_file = !is_lit && alu_op != ALU_PASS_A && alu_op != ALU_ZERO;
      case (alu_op)
        ALU_ADD, ALU_SUB: begin
          upd_c = 1'b1;
          upd_hc = 1'b1;
          upd_z = 1'b1;
        end
        ALU_RR, ALU_RL: upd_c = 1'b1;
        ALU_PASS_A, ALU_SWAP: upd_z = 1'b0;
        ALU_PASS_B: upd_z = !is_lit;
        default: upd_z = 1'b1;
      endcase
      if (!is_lit && alu_op == ALU_PASS_A) begin
        dest_w = 1'b0;
        dest_f = 1'b1;
      end
    end
  end

  // special registers are answered here, never on the data bus
  always_comb begin
    int_hit = 1'b1;
    int_rd = 8'h00;
    case (data_addr_reg[6:0])
      INDF_ADDR: int_rd = 8'h00;
      PCL_ADDR: int_rd = pc_reg[7:0];
      STATUS_ADDR: int_rd = status_reg;
      FSR_ADDR: int_rd = fsr_reg;
      default: int_hit = 1'b0;
    endcase
  end

  assign alu.a = w_reg;
  assign alu.b = is_lit ? ir_reg[7:0] : opnd_reg;
  assign alu.op = alu_op;
  assign alu.cin = status_reg[C_BIT];

  assign branch_now = (q_reg == QUARTER_PHASE_FOUR) && ir_valid_reg &&
    (is_goto || (dest_f && int_hit && data_addr_reg[6:0] == PCL_ADDR));

  always_comb begin
    q_next = q_reg;
    pc_next = pc_reg;
    fetch_next = fetch_reg;
    ir_next = ir_reg;
    ir_valid_next = ir_valid_reg;
    branch_pend_next = branch_pend_reg;
    target_next = target_reg;
    w_next = w_reg;
    status_next = status_reg;
    fsr_next = fsr_reg;
    opnd_next = opnd_reg;
    res_next = res_reg;
    rc_next = rc_reg;
    rdc_next = rdc_reg;
    rz_next = rz_reg;
    data_addr_next = data_addr_reg;
    case (q_reg)
      QUARTER_PHASE_ONE: begin
        q_next = QUARTER_PHASE_TWO;
        pc_next = branch_pend_reg ? target_reg : pc_reg + 13'h0001;
        ir_next = fetch_reg;
        ir_valid_next = !branch_pend_reg;
        branch_pend_next = 1'b0;
        // indirect access goes through the select register
        if (fetch_reg[6:0] == INDF_ADDR) begin
          data_addr_next = fsr_reg;
        end else begin
          data_addr_next = {status_reg[RP_BIT], fetch_reg[6:0]};
        end
      end
      QUARTER_PHASE_TWO: begin
        q_next = QUARTER_PHASE_THREE;
        opnd_next = int_hit ? int_rd : data_rd;
      end
      QUARTER_PHASE_THREE: begin
        q_next = QUARTER_PHASE_FOUR;
        res_next = alu.result;
        rc_next = alu.cout;
        rdc_next = alu.dcout;
        rz_next = alu.zout;
      end
      QUARTER_PHASE_FOUR: begin
        q_next = QUARTER_PHASE_ONE;
        fetch_next = prog_data;
        if (ir_valid_reg) begin
          if (dest_w) begin
            w_next = res_reg;
          end
          if (dest_f && int_hit) begin
            case (data_addr_reg[6:0])
              PCL_ADDR: target_next = {pc_reg[12:8], res_reg};
              STATUS_ADDR: status_next = res_reg;
              FSR_ADDR: fsr_next = res_reg;
              default: fsr_next = fsr_reg;
            endcase
          end
          if (is_goto) begin
            target_next = {pc_reg[12], ir_reg[GOTO_W-1:0]};
          end
          // flags land after a status write so the result flags win
          if (upd_c) begin
            status_next[C_BIT] = rc_reg;
          end
          if (upd_hc) begin
            status_next[HC_BIT] = rdc_reg;
          end
          if (upd_z) begin
            status_next[Z_BIT] = rz_reg;
          end
        end
        branch_pend_next = branch_now;
      end
      default: q_next = QUARTER_PHASE_ONE;
    endcase
    clk_out_next = clk_out_sel && (q_next == QUARTER_PHASE_THREE ||
      q_next == QUARTER_PHASE_FOUR);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_reg <= QUARTER_PHASE_ONE;
      pc_reg <= PC_RESET;
      fetch_reg <= NOP_INSTR;
      ir_reg <= NOP_INSTR;
      ir_valid_reg <= 1'b0;
      branch_pend_reg <= 1'b0;
      target_reg <= 13'h0000;
      w_reg <= W_RESET;
      status_reg <= STATUS_RESET;
      fsr_reg <= FSR_RESET;
      opnd_reg <= 8'h00;
      res_reg <= 8'h00;
      rc_reg <= 1'b0;
      rdc_reg <= 1'b0;
      rz_reg <= 1'b0;
      data_addr_reg <= 8'h00;
      clk_out_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
      pc_reg <= pc_next;
      fetch_reg <= fetch_next;
      ir_reg <= ir_next;
      ir_valid_reg <= ir_valid_next;
      branch_pend_reg <= branch_pend_next;
      target_reg <= target_next;
      w_reg <= w_next;
      status_reg <= status_next;
      fsr_reg <= fsr_next;
      opnd_reg <= opnd_next;
      res_reg <= res_next;
      rc_reg <= rc_next;
      rdc_reg <= rdc_next;
      rz_reg <= rz_next;
      data_addr_reg <= data_addr_next;
      clk_out_reg <= clk_out_next;
    end
  end

  assign prog_addr = pc_reg;
  assign data_addr = data_addr_reg;
  assign data_wr = res_reg;
  assign instr_rate_clock_out = clk_out_reg;
  // strobes are combinational; the memory answers within the quarter
  assign data_rd_en = (q_reg == QUARTER_PHASE_TWO) && ir_valid_reg &&
    reads_file && !int_hit;
  assign data_wr_en = (q_reg == QUARTER_PHASE_FOUR) && ir_valid_reg &&
    dest_f && !int_hit;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_rest_of_cycle;
    q_reg == QUARTER_PHASE_TWO ##1 q_reg == QUARTER_PHASE_THREE ##1
      q_reg == QUARTER_PHASE_FOUR ##1 q_reg == QUARTER_PHASE_ONE;
  endsequence
  property p_quarter_rotate;
    q_reg == QUARTER_PHASE_ONE |=> s_rest_of_cycle;
  endproperty
  a_quarter_rotate: assert property (p_quarter_rotate)
    else $error("quarter phases out of order");

  property p_read_in_q2;
    data_rd_en |-> q_reg == QUARTER_PHASE_TWO && !int_hit;
  endproperty
  a_read_in_q2: assert property (p_read_in_q2)
    else $error("operand read outside second quarter");

  property p_write_in_q4;
    data_wr_en |-> q_reg == QUARTER_PHASE_FOUR && data_wr == res_reg;
  endproperty
  a_write_in_q4: assert property (p_write_in_q4)
    else $error("destination write outside fourth quarter");

  // the address moves on the edge that leaves quarter one
  property p_fetch_steady;
    q_reg == QUARTER_PHASE_TWO |=> $stable(prog_addr) [*3];
  endproperty
  a_fetch_steady: assert property (p_fetch_steady)
    else $error("program address moved inside a cycle");

  property p_pc_step;
    q_reg == QUARTER_PHASE_ONE && !branch_pend_reg |=>
      prog_addr == $past(prog_addr) + 13'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("program counter did not step by one");

  sequence s_dropped_cycle;
    (!ir_valid_reg) [*4] ##1 ir_valid_reg;
  endsequence
  property p_branch_two_cycles;
    // the branch itself still reads valid until the next quarter one edge
    branch_now |=> ir_valid_reg ##1 s_dropped_cycle;
  endproperty
  a_branch_two_cycles: assert property (p_branch_two_cycles)
    else $error("prefetched word not discarded after branch");

  property p_sub_borrow;
    alu.op == ALU_SUB |-> alu.cout == (alu.b >= alu.a) &&
      alu.dcout == (alu.b[3:0] >= alu.a[3:0]);
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("subtract borrow flags wrong");

  property p_add_sum;
    alu.op == ALU_ADD |-> {alu.cout, alu.result} ==
      {1'b0, alu.a} + {1'b0, alu.b};
  endproperty
  a_add_sum: assert property (p_add_sum)
    else $error("add result or carry wrong");

  property p_w_only_q4;
    $changed(w_reg) |-> $past(q_reg) == QUARTER_PHASE_FOUR;
  endproperty
  a_w_only_q4: assert property (p_w_only_q4)
    else $error("working register changed outside fourth quarter");

  property p_zero_flag;
    q_reg == QUARTER_PHASE_FOUR && ir_valid_reg && upd_z |=>
      status_reg[Z_BIT] == ($past(res_reg) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag does not match result");

  property p_clock_out;
    q_reg == QUARTER_PHASE_TWO && clk_out_sel |=>
      instr_rate_clock_out [*2] ##1 !instr_rate_clock_out;
  endproperty
  a_clock_out: assert property (p_clock_out)
    else $error("clock output not at instruction rate");

  property p_literal_operand;
    q_reg == QUARTER_PHASE_THREE && is_lit |-> alu.b == ir_reg[7:0];
  endproperty
  a_literal_operand: assert property (p_literal_operand)
    else $error("literal not used as operand");
endmodule
`default_nettype wire

// file: bench/rca_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module rca_mem_model import rca_pkg::*; (
  input wire logic sys_clk, // core clock
  input wire logic [12:0] prog_addr, // fetch address
  output logic [13:0] prog_data, // instruction word
  input wire logic [7:0] data_addr, // file address
  input wire logic data_rd_en, // operand read strobe
  output logic [7:0] data_rd, // operand data
  input wire logic data_wr_en, // destination write strobe
  input wire logic [7:0] data_wr // destination data
);
  logic [13:0] rom [0:8191];
  logic [7:0] ram [0:255];
  logic [7:0] last_rd;
  initial begin
    last_rd = 8'h00;
    for (int i = 0; i < 8192; i++) rom[i] = NOP_INSTR;
    for (int i = 0; i < 256; i++) ram[i] = 8'h00;
  end
  // asynchronous program store, always answers within the fetch cycle
  assign prog_data = rom[prog_addr];
  // outside the strobe the bus shows stale inverted data, never a match
  assign data_rd = data_rd_en ? ram[data_addr] : ~last_rd;
  always @(posedge sys_clk) begin
    if (data_rd_en) last_rd <= ram[data_addr];
    if (data_wr_en) ram[data_addr] <= data_wr;
  end
endmodule
`default_nettype wire

// file: bench/risc_core_alu_datapath_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module risc_core_alu_datapath_tb_top;
  import rca_pkg::*;
  logic sys_clk;
  logic reset;
  logic [12:0] prog_addr;
  logic [13:0] prog_data;
  logic [7:0] data_addr;
  logic data_rd_en;
  logic [7:0] data_rd;
  logic data_wr_en;
  logic [7:0] data_wr;
  logic clk_out_sel;
  logic instr_rate_clock_out;
  logic [1:0] q_reg;
  int n_errors = 0;
  int cmp_count = 0;
  int pc_i;

  rca_core dut (
    .sys_clk(sys_clk), .reset(reset), .prog_addr(prog_addr),
    .prog_data(prog_data), .data_addr(data_addr),
    .data_rd_en(data_rd_en), .data_rd(data_rd),
    .data_wr_en(data_wr_en), .data_wr(data_wr),
    .clk_out_sel(clk_out_sel),
    .instr_rate_clock_out(instr_rate_clock_out)
  );
  rca_mem_model mem (
    .sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_rd_en(data_rd_en), .data_rd(data_rd),
    .data_wr_en(data_wr_en), .data_wr(data_wr)
  );

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // quarter index, 0 = quarter one; the cycle after release is already in it
  always @(posedge sys_clk) q_reg <= reset ? 2'd0 : q_reg + 2'd1;

  function automatic logic [13:0] lit(input logic [3:0] op,
                                      input logic [7:0] k);
    return {CLS_LIT, op, k};
  endfunction
  function automatic logic [13:0] fil(input logic [3:0] op, input logic d,
                                      input logic [6:0] f);
    return {CLS_FILE, op, d, f};
  endfunction
  function automatic logic internal(input logic [6:0] a);
    return a == INDF_ADDR || a == PCL_ADDR || a == STATUS_ADDR ||
      a == FSR_ADDR;
  endfunction

  // bus timing and clock output are watched on every cycle
  always @(negedge sys_clk) begin
    if (!reset) begin
      `CHK(instr_rate_clock_out, clk_out_sel & q_reg[1])
      if (data_rd_en) `CHK(q_reg, 2'd1)
      if (data_wr_en) `CHK(q_reg, 2'd3)
      if (data_rd_en | data_wr_en) `CHK(internal(data_addr[6:0]), 1'b0)
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // reset first so the old program and clock select never run half changed
  task automatic clear_rom();
    reset = 1'b1;
    for (int i = 0; i < 64; i++) mem.rom[i] = NOP_INSTR;
    pc_i = 0;
  endtask
  task automatic emit(input logic [13:0] w);
    mem.rom[pc_i] = w;
    pc_i++;
  endtask
  task automatic run(input int n);
    step(2);
    `CHK(prog_addr, PC_RESET)
    `CHK(data_rd_en | data_wr_en | instr_rate_clock_out, 1'b0)
    reset = 1'b0;
    step(n);
  endtask

  // subtraction borrow convention, literal and file forms
  task automatic sub_flags();
    clear_rom();
    clk_out_sel = 1'b1;
    mem.ram[8'h24] = 8'h10;
    emit(lit(4'h8, 8'h05)); emit(lit(4'h2, 8'h03));
    emit(fil(4'h0, 1'b1, 7'h20));
    emit(fil(4'h8, 1'b0, 7'h03)); emit(fil(4'h0, 1'b1, 7'h23));
    emit(lit(4'h8, 8'h03)); emit(lit(4'h2, 8'h05));
    emit(fil(4'h8, 1'b0, 7'h03)); emit(fil(4'h0, 1'b1, 7'h21));
    emit(lit(4'h8, 8'h07)); emit(lit(4'h2, 8'h07));
    emit(fil(4'h8, 1'b0, 7'h03)); emit(fil(4'h0, 1'b1, 7'h22));
    emit(lit(4'h8, 8'h01)); emit(fil(4'h2, 1'b1, 7'h24));
    emit(fil(4'h8, 1'b0, 7'h03)); emit(fil(4'h0, 1'b1, 7'h25));
    run(90);
    `CHK(mem.ram[8'h20], 8'hfe)
    `CHK(mem.ram[8'h23], 8'h00)
    `CHK(mem.ram[8'h21], 8'h03)
    `CHK(mem.ram[8'h22], 8'h07)
    `CHK(mem.ram[8'h24], 8'h0f)
    `CHK(mem.ram[8'h25], 8'h01)
  endtask

  // add, logic, shifts and single-operand ops, then a bank switch
  task automatic alu_ops();
    clear_rom();
    clk_out_sel = 1'b0;
    mem.ram[8'h40] = 8'h81;
    mem.ram[8'h45] = 8'h5a;
    emit(lit(4'h8, 8'h3c)); emit(fil(4'h0, 1'b1, 7'h30));
    emit(lit(4'h8, 8'hc4)); emit(fil(4'h7, 1'b1, 7'h30));
    emit(fil(4'hc, 1'b1, 7'h40));
    emit(fil(4'h8, 1'b0, 7'h03)); emit(fil(4'h0, 1'b1, 7'h31));
    emit(fil(4'hd, 1'b0, 7'h40)); emit(fil(4'h0, 1'b1, 7'h41));
    emit(lit(4'h8, 8'hf0)); emit(lit(4'h6, 8'h3c));
    emit(fil(4'h0, 1'b1, 7'h42));
    emit(lit(4'h5, 8'h0f)); emit(fil(4'h0, 1'b1, 7'h43));
    emit(lit(4'h4, 8'ha0)); emit(fil(4'h0, 1'b1, 7'h44));
    emit(fil(4'h9, 1'b1, 7'h44)); emit(fil(4'h3, 1'b1, 7'h44));
    emit(fil(4'ha, 1'b1, 7'h41)); emit(fil(4'hb, 1'b1, 7'h42));
    emit(fil(4'h1, 1'b1, 7'h45));
    emit(lit(4'h8, 8'h20)); emit(fil(4'h0, 1'b1, 7'h03));
    emit(lit(4'h8, 8'h77)); emit(fil(4'h0, 1'b1, 7'h20));
    run(115);
    `CHK(mem.ram[8'h30], 8'h00)
    `CHK(mem.ram[8'h31], 8'h07)
    `CHK(mem.ram[8'h40], 8'h03)
    `CHK(mem.ram[8'h41], 8'h31)
    `CHK(mem.ram[8'h42], 8'he6)
    `CHK(mem.ram[8'h43], 8'h0c)
    `CHK(mem.ram[8'h44], 8'h52)
    `CHK(mem.ram[8'h45], 8'h00)
    `CHK(mem.ram[8'ha0], 8'h77)
  endtask

  // pipeline timing, a jump and a branch by writing the low pc byte
  task automatic branches();
    clear_rom();
    clk_out_sel = 1'b1;
    emit({CLS_GOTO, 12'h010}); emit(lit(4'h8, 8'h99));
    emit(fil(4'h0, 1'b1, 7'h50));
    pc_i = 'h10;
    emit(lit(4'h8, 8'h11)); emit(fil(4'h0, 1'b1, 7'h50));
    emit(fil(4'h8, 1'b0, 7'h02)); emit(fil(4'h0, 1'b1, 7'h51));
    emit(lit(4'h8, 8'h20)); emit(fil(4'h0, 1'b1, 7'h02));
    emit(lit(4'h8, 8'hee)); emit(fil(4'h0, 1'b1, 7'h52));
    pc_i = 'h20;
    emit(lit(4'h8, 8'h22)); emit(fil(4'h0, 1'b1, 7'h52));
    // indirect write, then an indirect read-modify into the working register
    emit(lit(4'h8, 8'h60)); emit(fil(4'h0, 1'b1, 7'h04));
    emit(lit(4'h8, 8'h5c)); emit(fil(4'h0, 1'b1, 7'h00));
    emit(fil(4'ha, 1'b0, 7'h00)); emit(fil(4'h0, 1'b1, 7'h53));
    run(1);
    `CHK(prog_addr, 13'h0000)
    step(4);
    `CHK(prog_addr, 13'h0001)
    step(4);
    `CHK(prog_addr, 13'h0010)
    step(4);
    `CHK(prog_addr, 13'h0011)
    step(72);
    `CHK(mem.ram[8'h50], 8'h11)
    `CHK(mem.ram[8'h51], 8'h13)
    `CHK(mem.ram[8'h52], 8'h22)
    `CHK(mem.ram[8'h60], 8'h5c)
    `CHK(mem.ram[8'h53], 8'h5d)
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the three programs need well under 400 cycles
  initial begin
    #(100 * 3000);
    n_errors++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    clk_out_sel = 1'b0;
    step(20);
    sub_flags();
    alu_ops();
    branches();
    print_verdict();
  end
endmodule
`default_nettype wire
